// ### core/epi_top.sv
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
// Function
// - pin events detected only while pin function enable is one
// - detect mode selects edges only or edges plus levels
// - events always set the flag; interrupt is optional, flag can be polled
// - enabled pin gets internal pullup by default with pull disable zero
// - pull disable one turns internal pullup off
// - pin level offered to branch on pin level instructions when enabled
// - flag set on transition from deasserted to asserted level
// - edge and level mode holds flag set while pin stays asserted
// - vector high byte at lower address, low byte at next address
// - lower vector number has higher priority; highest pending is picked
// - set flag with local enable one sends request to cpu
// - mask clear: stack pcl, pch, x, a, ccr, set mask, fetch vector
// - real time at ffd0, pin at fffa, software at fffc; 31-24 unused; here vectors 24-31 are served from source_pending like the rest
// - vector 0 at fffe serves every reset cause
// - mode zero falling edges only; mode one falling edges and low levels
// - writing one to acknowledge clears flag; zero ignored; reads zero
// - pin enable one requests while flag is one; zero requests none
// - asynchronous wake path lets enabled pin wake stopped device
module epi_top (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [7:0] address,
   input wire logic [7:0] write_data,
   input wire logic write_strobe,
   input wire logic read_strobe,
   output logic [7:0] read_data,
   input wire logic request_pin_n,
   output logic pullup_enable,
   output logic pin_level_valid,
   output logic branch_if_pin_high,
   output logic branch_if_pin_low,
   output logic wake_request,
   input wire logic [epi_pkg::NUM_VECTORS-1:0] source_pending,
   input wire logic software_interrupt,
   input wire logic instruction_done,
   input wire logic [7:0] program_counter_low,
   input wire logic [7:0] program_counter_high,
   input wire logic [7:0] index_x,
   input wire logic [7:0] accumulator,
   input wire logic [7:0] condition_code_register,
   output logic irq_to_cpu,
   output logic stack_write,
   output logic [7:0] stack_data,
   output logic vector_read,
   output logic [15:0] vector_address,
   output logic [7:0] handler_high,
   output logic [7:0] handler_low,
   input wire logic [7:0] vector_byte,
   output logic entry_done
);
   logic pin_function_enable;
   logic detect_mode_select;
   logic pull_device_disable;
   logic pin_interrupt_enable;
   logic pin_event_flag;
   logic global_mask;
   logic pin_sync_n;
   logic pin_prev_n;
   logic pin_asserted;
   logic falling_edge;
   logic set_event;
   logic ack_write;
   logic status_write;
   logic cpu_write;
   logic [epi_pkg::NUM_VECTORS-1:0] pending_all;
   logic any_pending;
   logic [4:0] best_vector;
   logic [4:0] taken_vector;
   logic [2:0] stack_count;
   epi_pkg::epi_state_t state;
   epi_pkg::epi_state_t next_state;
   logic [7:0] next_read_data;

   epi_sync u_sync (
      .clock(clock),
      .rst_n(rst_n),
      .async_in(request_pin_n),
      .sync_out(pin_sync_n)
   );

   // previous synchronised level for edge detection
   // resets to the idle high level so that leaving reset makes no false edge
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         pin_prev_n <= 1'b1;
      else
         pin_prev_n <= pin_sync_n;
   end

   assign pin_asserted = ~pin_sync_n;
   assign falling_edge = pin_prev_n & ~pin_sync_n;
   assign set_event = pin_function_enable &
      (falling_edge | (detect_mode_select & pin_asserted));
   // register write decode
   assign status_write = write_strobe && (address == epi_pkg::REG_STATUS_CONTROL);
   assign cpu_write = write_strobe && (address == epi_pkg::REG_CPU_CONTROL);
   assign ack_write = status_write && write_data[epi_pkg::BIT_ACKNOWLEDGE];

   // control bits of the status and control register
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin_function_enable <= epi_pkg::RESET_STATUS_CONTROL[epi_pkg::BIT_FUNCTION_ENABLE];
         detect_mode_select <= epi_pkg::RESET_STATUS_CONTROL[epi_pkg::BIT_DETECT_MODE];
         pull_device_disable <= epi_pkg::RESET_STATUS_CONTROL[epi_pkg::BIT_PULL_DISABLE];
         pin_interrupt_enable <= epi_pkg::RESET_STATUS_CONTROL[epi_pkg::BIT_PIN_IRQ_ENABLE];
      end
      else if (status_write)
      begin
         pin_function_enable <= write_data[epi_pkg::BIT_FUNCTION_ENABLE];
         detect_mode_select <= write_data[epi_pkg::BIT_DETECT_MODE];
         pull_device_disable <= write_data[epi_pkg::BIT_PULL_DISABLE];
         pin_interrupt_enable <= write_data[epi_pkg::BIT_PIN_IRQ_ENABLE];
      end
   end

   // event flag: a set in the same cycle as an acknowledge wins
   // a low pin in edge and level mode re-sets it each cycle, so the ack loses
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         pin_event_flag <= epi_pkg::RESET_STATUS_CONTROL[epi_pkg::BIT_EVENT_FLAG];
      else if (set_event)
         pin_event_flag <= 1'b1;
      else if (ack_write)
         pin_event_flag <= 1'b0;
   end

   assign pullup_enable = pin_function_enable & ~pull_device_disable;
   assign pin_level_valid = pin_function_enable;
   assign branch_if_pin_high = pin_function_enable & pin_sync_n;
   assign branch_if_pin_low = pin_function_enable & ~pin_sync_n;
   // unsynchronised on purpose: it must work while the clock is stopped
   // unclocked wake path
   assign wake_request = pin_function_enable & ~request_pin_n;

   // pending vector set; pin and software sources merged in
   // software interrupt joins vector 1 even when its source bit is clear
   always_comb
   begin
      pending_all = source_pending;
      pending_all[epi_pkg::VEC_PIN] = source_pending[epi_pkg::VEC_PIN] |
         (pin_interrupt_enable & pin_event_flag);
      pending_all[epi_pkg::VEC_SOFTWARE] = source_pending[epi_pkg::VEC_SOFTWARE] |
         software_interrupt;
   end

   // combinational scan: a new request is seen in the cycle it arrives
   // lowest number wins
   epi_prio #(
      .N(epi_pkg::NUM_VECTORS)
   ) u_prio (
      .pending(pending_all),
      .any(any_pending),
      .index(best_vector)
   );

   assign irq_to_cpu = any_pending;

   // cpu entry sequence state register
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         state <= epi_pkg::EPI_IDLE;
      else
         state <= next_state;
   end

   // cpu entry sequence next state
   always_comb
   begin
      next_state = state;
      case (state)
         epi_pkg::EPI_IDLE:
            // vectors 0 and 1 ignore the mask: reset and software entry
            // wait for unmasked request at instruction end
            if (any_pending && (!global_mask || pending_all[epi_pkg::VEC_RESET] ||
               pending_all[epi_pkg::VEC_SOFTWARE]) && instruction_done)
               next_state = epi_pkg::EPI_STACK;
         epi_pkg::EPI_STACK:
            if (stack_count == epi_pkg::STACK_LAST)
               next_state = epi_pkg::EPI_MASK;
         epi_pkg::EPI_MASK:
            next_state = epi_pkg::EPI_FETCH_HIGH;
         epi_pkg::EPI_FETCH_HIGH:
            next_state = epi_pkg::EPI_FETCH_LOW;
         epi_pkg::EPI_FETCH_LOW:
            next_state = epi_pkg::EPI_IDLE;
         default:
            next_state = epi_pkg::EPI_IDLE;
      endcase
   end

   // stacking byte counter and captured vector
   // the vector is caught at the decision and refreshed at the mask step only
   // while a request stands, so a withdrawn source never sends the cpu to reset
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         stack_count <= 3'h0;
         taken_vector <= epi_pkg::VEC_RESET;
      end
      else if (state == epi_pkg::EPI_IDLE)
      begin
         stack_count <= 3'h0;
         if (next_state == epi_pkg::EPI_STACK)
            taken_vector <= best_vector;
      end
      else if (state == epi_pkg::EPI_STACK)
         stack_count <= stack_count + 3'h1;
      else if (state == epi_pkg::EPI_MASK && any_pending)
         taken_vector <= best_vector;
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         stack_write <= 1'b0;
         stack_data <= 8'h00;
      end
      else
      begin
         stack_write <= (state == epi_pkg::EPI_STACK);
         case (stack_count)
            epi_pkg::STACK_LOW_PC: stack_data <= program_counter_low;
            epi_pkg::STACK_HIGH_PC: stack_data <= program_counter_high;
            epi_pkg::STACK_X: stack_data <= index_x;
            epi_pkg::STACK_A: stack_data <= accumulator;
            epi_pkg::STACK_CCR: stack_data <= condition_code_register;
            default: stack_data <= 8'h00;
         endcase
      end
   end

   // global mask: software writes it, entry sequence sets it
   // the entry step outranks a software write in the same cycle
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         global_mask <= epi_pkg::RESET_GLOBAL_MASK;
      else if (state == epi_pkg::EPI_MASK)
         global_mask <= 1'b1;
      else if (cpu_write)
         global_mask <= write_data[epi_pkg::BIT_GLOBAL_MASK];
   end

   // vector fetch address and handler bytes
   // vector_byte answers in the cycle after each vector_read edge
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         vector_read <= 1'b0;
         vector_address <= epi_pkg::VECTOR_TOP;
         handler_high <= 8'h00;
         handler_low <= 8'h00;
         entry_done <= 1'b0;
      end
      else
      begin
         vector_read <= 1'b0;
         entry_done <= 1'b0;
         if (state == epi_pkg::EPI_FETCH_HIGH)
         begin
            vector_read <= 1'b1;
            vector_address <= epi_pkg::VECTOR_TOP - {10'h000, taken_vector, 1'b0};
         end
         else if (state == epi_pkg::EPI_FETCH_LOW)
         begin
            vector_read <= 1'b1;
            handler_high <= vector_byte;
            vector_address <= vector_address + 16'h0001;
         end
         else if (vector_read)
         begin
            handler_low <= vector_byte;
            entry_done <= 1'b1;
         end
      end
   end

   // read data mux; acknowledge bit always reads zero
   // unmapped offsets read as zero
   always_comb
   begin
      next_read_data = 8'h00;
      case (address)
         epi_pkg::REG_STATUS_CONTROL:
         begin
            next_read_data[epi_pkg::BIT_PULL_DISABLE] = pull_device_disable;
            next_read_data[epi_pkg::BIT_FUNCTION_ENABLE] = pin_function_enable;
            next_read_data[epi_pkg::BIT_EVENT_FLAG] = pin_event_flag;
            next_read_data[epi_pkg::BIT_PIN_IRQ_ENABLE] = pin_interrupt_enable;
            next_read_data[epi_pkg::BIT_DETECT_MODE] = detect_mode_select;
         end
         epi_pkg::REG_PENDING: next_read_data = {3'h0, best_vector};
         epi_pkg::REG_VECTOR: next_read_data = {3'h0, taken_vector};
         epi_pkg::REG_CPU_CONTROL:
         begin
            next_read_data[epi_pkg::BIT_GLOBAL_MASK] = global_mask;
            next_read_data[epi_pkg::BIT_PIN_LEVEL] = pin_sync_n;
         end
         default: next_read_data = 8'h00;
      endcase
   end

   // read data stands one cycle after the strobe only
   // zero outside the answer cycle, so no stale value looks like data
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         read_data <= 8'h00;
      else if (read_strobe)
         read_data <= next_read_data;
      else
         read_data <= 8'h00;
   end
endmodule : epi_top

// ### core/epi_pkg.sv
package epi_pkg;
   // register offsets of the pin request status and control block
   localparam logic [7:0] REG_STATUS_CONTROL = 8'h00;
   localparam logic [7:0] REG_PENDING = 8'h01;
   localparam logic [7:0] REG_VECTOR = 8'h02;
   localparam logic [7:0] REG_CPU_CONTROL = 8'h03;
   // field positions in the status and control register
   localparam int BIT_DETECT_MODE = 0;
   localparam int BIT_PIN_IRQ_ENABLE = 1;
   localparam int BIT_ACKNOWLEDGE = 2;
   localparam int BIT_EVENT_FLAG = 3;
   localparam int BIT_FUNCTION_ENABLE = 4;
   localparam int BIT_PULL_DISABLE = 6;
   // field positions in the cpu control register
   localparam int BIT_GLOBAL_MASK = 0;
   localparam int BIT_PIN_LEVEL = 7;
   // reset values
   localparam logic [7:0] RESET_STATUS_CONTROL = 8'h00;
   localparam logic RESET_GLOBAL_MASK = 1'b1;
   // vector table layout
   localparam int NUM_VECTORS = 32;
   localparam logic [15:0] VECTOR_TOP = 16'hFFFE;
   localparam logic [4:0] VEC_RESET = 5'h00;
   localparam logic [4:0] VEC_SOFTWARE = 5'h01;
   localparam logic [4:0] VEC_PIN = 5'h02;
   localparam logic [4:0] VEC_REAL_TIME = 5'h17;
   // stacking sequence length: low pc, high pc, x, a, condition codes
   localparam int STACK_BYTES = 5;
   localparam logic [2:0] STACK_LAST = 3'h4;
   localparam logic [2:0] STACK_LOW_PC = 3'h0;
   localparam logic [2:0] STACK_HIGH_PC = 3'h1;
   localparam logic [2:0] STACK_X = 3'h2;
   localparam logic [2:0] STACK_A = 3'h3;
   localparam logic [2:0] STACK_CCR = 3'h4;
   // cpu entry states
   typedef enum logic [2:0] {EPI_IDLE, EPI_STACK, EPI_MASK, EPI_FETCH_HIGH,
      EPI_FETCH_LOW} epi_state_t;
endpackage : epi_pkg

// ### core/epi_sync.sv
`timescale 1ns/1ns
// two flop synchroniser for the request pin
module epi_sync (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic async_in,
   output logic sync_out
);
   logic stage1;

   // first stage feeds only the second; pin idles high
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         stage1 <= 1'b1;
         sync_out <= 1'b1;
      end
      else
      begin
         stage1 <= async_in;
         sync_out <= stage1;
      end
   end
endmodule : epi_sync

// ### core/epi_prio.sv
`timescale 1ns/1ns
// picks the lowest numbered pending vector
module epi_prio #(
   parameter int N = 32
) (
   input wire logic [N-1:0] pending,
   output logic any,
   output logic [4:0] index
);
   logic [4:0] found [N:0];
   logic hit [N:0];

   assign found[N] = 5'h00;
   assign hit[N] = 1'b0;
   // scan from the top so the lowest number wins
   genvar i;
   generate
      for (i = 0; i < N; i++)
      begin : g_scan
         assign hit[i] = pending[i] | hit[i+1];
         assign found[i] = pending[i] ? 5'(i) : found[i+1];
      end
   endgenerate
   assign any = hit[0];
   assign index = found[0];
endmodule : epi_prio

// ### bench/epi_pin_model.sv
`timescale 1ns/1ns
// far side: a switch pulling the request pin low, pulled up when released
module epi_pin_model (
   input wire logic clock,
   input wire logic hold_low,
   output logic pin_n
);
   initial pin_n = 1'b1;
   // pin moves a few ns after the edge, unrelated to the sampling point
   always @(posedge clock)
   begin
      pin_n <= #7 ~hold_low;
   end
endmodule : epi_pin_model

// ### bench/epi_top_sva.sv
`timescale 1ns/1ns
// checker on the ports of the pin request and vector block
module epi_top_sva (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic request_pin_n,
   input wire logic pullup_enable,
   input wire logic pin_level_valid,
   input wire logic branch_if_pin_high,
   input wire logic branch_if_pin_low,
   input wire logic wake_request,
   input wire logic [31:0] source_pending,
   input wire logic [7:0] program_counter_low,
   input wire logic [7:0] program_counter_high,
   input wire logic [7:0] index_x,
   input wire logic [7:0] accumulator,
   input wire logic [7:0] condition_code_register,
   input wire logic irq_to_cpu,
   input wire logic stack_write,
   input wire logic [7:0] stack_data,
   input wire logic vector_read,
   input wire logic [15:0] vector_address,
   input wire logic entry_done
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   // five stacked bytes in fixed order
   sequence s_stack;
      stack_data == program_counter_low ##1 stack_data == program_counter_high
      ##1 stack_data == index_x ##1 stack_data == accumulator
      ##1 stack_data == condition_code_register;
   endsequence
   // two byte vector fetch, high byte at the even address
   sequence s_fetch;
      (vector_address[0] == 1'b0 && vector_address >= 16'hFFC0)
      ##1 (vector_read && vector_address == $past(vector_address) + 16'h0001);
   endsequence
   a_pullup_needs_enable: assert property (pullup_enable |-> pin_level_valid)
      else $error("pullup on while pin function off");
   a_wake_path_level: assert property (wake_request == (pin_level_valid && !request_pin_n))
      else $error("wake request does not follow enabled pin");
   a_branch_level_view: assert property ((branch_if_pin_high ^ branch_if_pin_low) == pin_level_valid)
      else $error("branch level view wrong");
   a_pending_raises_irq: assert property (source_pending != 32'h0000_0000 |-> irq_to_cpu)
      else $error("pending source without cpu request");
   a_stack_byte_order: assert property ($rose(stack_write) |-> s_stack)
      else $error("stacked bytes out of order");
   a_stack_five_bytes: assert property ($rose(stack_write) |-> stack_write [*5] ##1 !stack_write)
      else $error("stacking not five bytes");
   a_vector_byte_pair: assert property ($rose(vector_read) |-> s_fetch)
      else $error("vector fetch address pair wrong");
   a_fetch_after_stack: assert property ($fell(stack_write) |-> ##[1:2] $rose(vector_read))
      else $error("no vector fetch after stacking");
   a_entry_done_time: assert property ($rose(vector_read) |-> ##2 entry_done)
      else $error("entry not closed after fetch");
endmodule : epi_top_sva

// ### bench/tb.sv
`timescale 1ns/1ns
module tb;
   logic clock = 0, rst_n = 0, write_strobe = 0, read_strobe = 0, hold_low = 0;
   logic software_interrupt = 0, instruction_done = 0, request_pin_n;
   logic [7:0] address = 0, write_data = 0, read_data, rd_val;
   logic [7:0] program_counter_low = 0, program_counter_high = 0, index_x = 0;
   logic [7:0] accumulator = 0, condition_code_register = 0, vector_byte;
   logic [31:0] source_pending = 0, pend;
   logic pullup_enable, pin_level_valid, branch_if_pin_high, branch_if_pin_low;
   logic wake_request, irq_to_cpu, stack_write, vector_read, entry_done;
   logic [7:0] stack_data, handler_high, handler_low;
   logic [15:0] vector_address;
   int num_errors = 0, checks = 0, cycles = 0, seed = 67;
   epi_top dut (.clock, .rst_n, .address, .write_data, .write_strobe, .read_strobe,
      .read_data, .request_pin_n, .pullup_enable, .pin_level_valid, .branch_if_pin_high,
      .branch_if_pin_low, .wake_request, .source_pending, .software_interrupt,
      .instruction_done, .program_counter_low, .program_counter_high, .index_x,
      .accumulator, .condition_code_register, .irq_to_cpu, .stack_write, .stack_data,
      .vector_read, .vector_address, .handler_high, .handler_low, .vector_byte, .entry_done);
   epi_pin_model pin (.clock, .hold_low, .pin_n(request_pin_n));
   // vector memory content derived from the address
   function automatic logic [7:0] mem(input logic [15:0] a);
      return ~a[7:0];
   endfunction : mem
   function automatic logic [4:0] best(input logic [31:0] p);
      best = 5'h00;
      for (int i = 31; i >= 0; i--)
      begin
         if (p[i]) best = 5'(i);
      end
   endfunction : best
   assign vector_byte = mem(vector_address);
   initial forever #10 clock = ~clock;
   // cycle ceiling cuts a hang short
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         num_errors++;
         wrap_up();
      end
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("wrong value at %0t: got %h want %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      address <= a;
      write_data <= d;
      write_strobe <= 1;
      @(posedge clock);
      write_strobe <= 0;
      @(negedge clock);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock);
      address <= a;
      read_strobe <= 1;
      @(posedge clock);
      read_strobe <= 0;
      @(negedge clock);
      d = read_data;
   endtask : rd
   task automatic pin_to(input logic low);
      @(posedge clock) hold_low <= low;
      repeat (6) @(posedge clock);
   endtask : pin_to
   task automatic flag_is(input logic exp);
      rd(8'h00, rd_val);
      chk(rd_val[3], exp);
   endtask : flag_is
   // one interrupt entry with random cpu registers held steady
   task automatic entry(input logic [31:0] p, input logic swi, input logic [4:0] n);
      int k;
      k = 0;
      @(posedge clock);
      {program_counter_low, program_counter_high, index_x, accumulator} <= $random(seed);
      condition_code_register <= 8'($random(seed));
      source_pending <= p;
      software_interrupt <= swi;
      instruction_done <= 1;
      // one boundary only, so a request still standing cannot start a second entry
      @(posedge clock);
      instruction_done <= 0;
      while (entry_done !== 1'b1 && k < 60)
      begin
         @(posedge clock);
         #1 k++;
      end
      @(posedge clock);
      source_pending <= 0;
      software_interrupt <= 0;
      chk(k < 60, 1'b1);
      chk(handler_high, mem(16'hFFFE - 16'(2 * n)));
      chk(handler_low, mem(16'hFFFF - 16'(2 * n)));
      rd(epi_pkg::REG_VECTOR, rd_val);
      chk(rd_val, n);
      rd(epi_pkg::REG_CPU_CONTROL, rd_val);
      chk(rd_val[0], 1'b1);
   endtask : entry
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : wrap_up
   initial
   begin
      repeat (5) @(posedge clock);
      rst_n <= 1;
      rd(epi_pkg::REG_STATUS_CONTROL, rd_val);
      chk(rd_val, epi_pkg::RESET_STATUS_CONTROL);
      rd(8'h3C, rd_val);
      chk(rd_val, 8'h00);
      $display("test reset done");
      for (int i = 0; i < 6; i++)
      begin
         pend = (i == 0) ? 32'h8000_0000 : (i == 1) ? 32'h0080_0000 : $random(seed);
         pend = (pend & 32'hFFFF_FFFC) | 32'h8000_0000;
         wr(epi_pkg::REG_CPU_CONTROL, 8'h00);
         entry(pend, 1'b0, best(pend));
      end
      $display("test priority done");
      // edge missed while pin function is off
      pin_to(1);
      pin_to(0);
      flag_is(0);
      wr(8'h00, 8'h10);
      chk({pullup_enable, pin_level_valid, branch_if_pin_high}, 3'b111);
      wr(8'h00, 8'h50);
      chk(pullup_enable, 1'b0);
      rd(8'h00, rd_val);
      chk(rd_val, 8'h50);
      pin_to(1);
      chk(branch_if_pin_low, 1'b1);
      flag_is(1);
      chk(irq_to_cpu, 1'b0);
      wr(8'h00, 8'h54);
      flag_is(0);
      wr(8'h00, 8'h51);
      wr(8'h00, 8'h55);
      flag_is(1);
      pin_to(0);
      wr(8'h00, 8'h55);
      flag_is(0);
      rd(8'h00, rd_val);
      chk(rd_val[2], 1'b0);
      pin_to(1);
      pin_to(0);
      wr(8'h00, 8'h52);
      chk(irq_to_cpu, 1'b1);
      rd(epi_pkg::REG_PENDING, rd_val);
      chk(rd_val, epi_pkg::VEC_PIN);
      $display("test pin done");
      wr(epi_pkg::REG_CPU_CONTROL, 8'h00);
      entry(32'h0000_0000, 1'b0, epi_pkg::VEC_PIN);
      wr(8'h00, 8'h16);
      entry(32'h0000_0000, 1'b1, epi_pkg::VEC_SOFTWARE);
      entry(32'h0000_0001, 1'b1, epi_pkg::VEC_RESET);
      $display("test vectors done");
      wrap_up();
   end
endmodule : tb
bind epi_top epi_top_sva chk_i (.clock, .rst_n, .request_pin_n, .pullup_enable,
   .pin_level_valid, .branch_if_pin_high, .branch_if_pin_low, .wake_request, .source_pending,
   .program_counter_low, .program_counter_high, .index_x, .accumulator,
   .condition_code_register, .irq_to_cpu, .stack_write, .stack_data, .vector_read,
   .vector_address, .entry_done);
